// ---- hw/pifp_pkg.sv ----
// package: offsets, field layout and reset values of the peripheral interrupt block
package pifp_pkg;
	// ********************
	// register byte offsets
	// ********************
	localparam logic [4:0] OFF_FLAGS_TWO = 5'h00;
	localparam logic [4:0] OFF_EN_ONE    = 5'h04;
	localparam logic [4:0] OFF_EN_TWO    = 5'h08;
	localparam logic [4:0] OFF_PRIO_ONE  = 5'h0C;
	localparam logic [4:0] OFF_PRIO_TWO  = 5'h10;
	localparam logic [4:0] OFF_RST_CTRL  = 5'h14;
	localparam logic [4:0] OFF_GLOBAL    = 5'h18;
	// ********************
	// bit positions
	// ********************
	localparam int B_CLK_FAIL = 7;
	localparam int B_CMP      = 6;
	localparam int B_NONE     = 5;
	localparam int B_NV_WR    = 4;
	localparam int B_BUS_COL  = 3;
	localparam int B_VOLT     = 2;
	localparam int B_TMR3     = 1;
	localparam int B_CCP2     = 0;
	localparam int B_PAR_PORT = 7;
	localparam int B_PRIO_EN  = 7;
	localparam int B_SBOR     = 6;
	localparam int B_RST_INS  = 4;
	localparam int B_WDOG     = 3;
	localparam int B_SLEEP    = 2;
	localparam int B_POR      = 1;
	localparam int B_BROWN    = 0;
	localparam int B_MGIE     = 7;
	localparam int B_PGIE     = 6;
	// ********************
	// masks and reset values
	// ********************
	localparam logic [7:0] MASK_TWO    = 8'hDF;
	localparam logic [7:0] MASK_ONE_28 = 8'h7F;
	localparam logic [7:0] RST_FLAGS   = 8'h00;
	localparam logic [7:0] RST_EN      = 8'h00;
	localparam logic [7:0] RST_PRIO    = 8'hFF;
	localparam logic [7:0] RST_CAUSE   = 8'h1C;
	localparam logic [1:0] MODE_CAP    = 2'h0;
	localparam logic [1:0] MODE_CMPR   = 2'h1;
	localparam logic [1:0] MODE_PWM    = 2'h2;

	// peripheral event strobes, one cycle each, except internal_oscillator, which is a level
	typedef struct packed {
		logic clock_fail;
		logic internal_oscillator;
		logic nv_write_done;
		logic bus_collision;
		logic timer_three_ovf;
		logic capcomp_two_evt;
	} pifp_evt_t;

	// reset-cause events from the core
	typedef struct packed {
		logic reset_instr;
		logic watchdog_timeout;
		logic sleep_entry;
		logic watchdog_clear;
	} pifp_cause_t;

	typedef struct packed {
		logic [7:0] flags_two;
		logic [7:0] en_one;
		logic [7:0] en_two;
		logic [7:0] prio_one;
		logic [7:0] prio_two;
		logic [7:0] rst_ctrl;
		logic       mgie;
		logic       pgie;
		logic       cfg_done;
		logic [1:0] cmp_prev;
		logic       volt_prev;
		logic       ack;
		logic [7:0] dat;
		logic       irq_high;
		logic       irq_low;
	} pifp_state_t;
endpackage

// ---- hw/pifp_top.sv ----
// module: peripheral flag, enable and priority registers with request outputs
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module pifp_top
	import pifp_pkg::*;
#(
	parameter bit NARROW_PKG = 1'b0
) (
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [4:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	input  wire logic [7:0]  flags_one_in,
	input  wire pifp_evt_t   evt_in,
	input  wire logic [1:0]  comparator_out_in,
	input  wire logic        voltage_above_in,
	input  wire logic        voltage_trip_direction_in,
	input  wire logic [1:0]  capcomp_two_mode_in,
	input  wire pifp_cause_t cause_in,
	input  wire logic        soft_brownout_cfg_in,
	output logic             irq_high_out,
	output logic             irq_low_out,
	output logic             priority_levels_enable_out
);
	// ********************
	// helpers
	// ********************
	function automatic logic hit(input logic [4:0] adr, input logic [4:0] off);
		hit = (adr == off);
	endfunction

	localparam logic [7:0] MASK_ONE = NARROW_PKG ? MASK_ONE_28 : 8'hFF;

	pifp_state_t st;
	pifp_state_t next_st;
	logic        wr;
	logic        rd;
	logic [7:0]  wdat;
	logic [7:0]  set_two;
	logic [7:0]  f1;
	logic [15:0] act;
	logic [15:0] pri;
	logic        volt_trip;
	logic        wr_flags;

	assign wr   = wb_cyc_in & wb_stb_in & wb_we_in & st.ack & wb_sel_in[0];
	assign rd   = wb_cyc_in & wb_stb_in & ~st.ack;
	assign wdat = wb_dat_in[7:0];
	assign f1   = flags_one_in & MASK_ONE;

	// software write to the flag register, watched by the checks
	assign wr_flags = wr & hit(wb_adr_in, OFF_FLAGS_TWO);

	// trip direction: 1 watches a rise above the level, 0 a fall below
	assign volt_trip = voltage_trip_direction_in ? (voltage_above_in & ~st.volt_prev)
		: (~voltage_above_in & st.volt_prev);

	// ********************
	// hardware set terms
	// ********************
	always_comb begin
		set_two = 8'h00;
		set_two[B_CLK_FAIL] = evt_in.clock_fail & evt_in.internal_oscillator;
		set_two[B_CMP]      = |(comparator_out_in ^ st.cmp_prev);
		set_two[B_NV_WR]    = evt_in.nv_write_done;
		set_two[B_BUS_COL]  = evt_in.bus_collision;
		set_two[B_VOLT]     = volt_trip;
		set_two[B_TMR3]     = evt_in.timer_three_ovf;
		set_two[B_CCP2]     = evt_in.capcomp_two_evt & ((capcomp_two_mode_in == MODE_CAP)
			| (capcomp_two_mode_in == MODE_CMPR));
	end

	// requests use the next flag value so that a set reaches the request outputs on the same edge as the flag
	assign act = {next_st.flags_two & st.en_two, f1 & st.en_one};
	assign pri = {st.prio_two, st.prio_one};

	// ********************
	// next state
	// ********************
	always_comb begin
		next_st = st;
		next_st.cmp_prev  = comparator_out_in;
		next_st.volt_prev = voltage_above_in;
		// flags set whatever the enables; a set beats a same-cycle clear
		if (wr && hit(wb_adr_in, OFF_FLAGS_TWO)) begin
			next_st.flags_two = (wdat | set_two) & MASK_TWO;
		end else begin
			next_st.flags_two = (st.flags_two | set_two) & MASK_TWO;
		end
		if (wr) begin
			if (hit(wb_adr_in, OFF_EN_ONE)) begin
				next_st.en_one = wdat & MASK_ONE;
			end else if (hit(wb_adr_in, OFF_EN_TWO)) begin
				next_st.en_two = wdat & MASK_TWO;
			end else if (hit(wb_adr_in, OFF_PRIO_ONE)) begin
				next_st.prio_one = wdat & MASK_ONE;
			end else if (hit(wb_adr_in, OFF_PRIO_TWO)) begin
				next_st.prio_two = wdat & MASK_TWO;
			end else if (hit(wb_adr_in, OFF_RST_CTRL)) begin
				// watchdog and power-down status are read-only
				next_st.rst_ctrl[B_PRIO_EN] = wdat[B_PRIO_EN];
				next_st.rst_ctrl[B_SBOR]    = wdat[B_SBOR];
				next_st.rst_ctrl[B_RST_INS] = wdat[B_RST_INS];
				next_st.rst_ctrl[B_POR]     = wdat[B_POR];
				next_st.rst_ctrl[B_BROWN]   = wdat[B_BROWN];
			end else if (hit(wb_adr_in, OFF_GLOBAL)) begin
				next_st.mgie = wdat[B_MGIE];
				next_st.pgie = wdat[B_PGIE];
			end
		end
		// reset-cause events override a software write of the same cycle
		if (cause_in.reset_instr) begin
			next_st.rst_ctrl[B_RST_INS] = 1'b0;
		end
		if (cause_in.watchdog_clear) begin
			next_st.rst_ctrl[B_WDOG]  = 1'b1;
			next_st.rst_ctrl[B_SLEEP] = 1'b1;
		end
		if (cause_in.watchdog_timeout) begin
			next_st.rst_ctrl[B_WDOG] = 1'b0;
		end
		if (cause_in.sleep_entry) begin
			next_st.rst_ctrl[B_SLEEP] = 1'b0;
		end
		// strap is caught on the first edge after release, never under reset
		if (!st.cfg_done) begin
			next_st.cfg_done = 1'b1;
			next_st.rst_ctrl[B_SBOR] = soft_brownout_cfg_in;
		end
		next_st.rst_ctrl[B_NONE] = 1'b0;
		// ********************
		// bus answer: ack one edge after request, write lands on the edge after the ack edge
		// ********************
		next_st.ack = rd;
		next_st.dat = 8'h00;
		if (rd) begin
			if (hit(wb_adr_in, OFF_FLAGS_TWO)) begin
				next_st.dat = st.flags_two;
			end else if (hit(wb_adr_in, OFF_EN_ONE)) begin
				next_st.dat = st.en_one;
			end else if (hit(wb_adr_in, OFF_EN_TWO)) begin
				next_st.dat = st.en_two;
			end else if (hit(wb_adr_in, OFF_PRIO_ONE)) begin
				next_st.dat = st.prio_one;
			end else if (hit(wb_adr_in, OFF_PRIO_TWO)) begin
				next_st.dat = st.prio_two;
			end else if (hit(wb_adr_in, OFF_RST_CTRL)) begin
				next_st.dat = st.rst_ctrl;
			end else if (hit(wb_adr_in, OFF_GLOBAL)) begin
				next_st.dat = {st.mgie, st.pgie, 6'h00};
			end
		end
		// ********************
		// request outputs
		// ********************
		if (st.rst_ctrl[B_PRIO_EN]) begin
			next_st.irq_high = st.mgie & |(act & pri);
			next_st.irq_low  = st.mgie & st.pgie & |(act & ~pri);
		end else begin
			next_st.irq_high = st.mgie & st.pgie & |act;
			next_st.irq_low  = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st           <= '0;
			st.flags_two <= RST_FLAGS;
			st.en_one    <= RST_EN;
			st.en_two    <= RST_EN;
			st.prio_one  <= RST_PRIO & MASK_ONE;
			st.prio_two  <= RST_PRIO & MASK_TWO;
			st.rst_ctrl  <= RST_CAUSE;
		end else begin
			st <= next_st;
		end
	end

	assign wb_ack_out                 = st.ack;
	assign wb_dat_out                 = {24'h000000, st.dat};
	assign irq_high_out               = st.irq_high;
	assign irq_low_out                = st.irq_low;
	assign priority_levels_enable_out = st.rst_ctrl[B_PRIO_EN];

	// ********************
	// checks
	// ********************
	AST_CLK_FAIL: assert property (@(posedge clk_in) disable iff (!rstn_in)
		evt_in.clock_fail && evt_in.internal_oscillator |=> st.flags_two[B_CLK_FAIL])
		else $error("clock fail flag not set");
	AST_CMP: assert property (@(posedge clk_in) disable iff (!rstn_in)
		comparator_out_in != $past(comparator_out_in) && st.cfg_done
		|=> st.flags_two[B_CMP])
		else $error("comparator flag missed");
	AST_PWM: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!st.flags_two[B_CCP2] && capcomp_two_mode_in == MODE_PWM
		&& !(wr && hit(wb_adr_in, OFF_FLAGS_TWO)) |=> !st.flags_two[B_CCP2])
		else $error("capture flag set in pwm");
	AST_BIT5: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!st.flags_two[B_NONE] && !st.en_two[B_NONE] && !st.prio_two[B_NONE]
		&& !st.rst_ctrl[B_NONE])
		else $error("bit 5 not zero");
	AST_SINGLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!st.rst_ctrl[B_PRIO_EN] && !st.pgie |=> !irq_high_out && !irq_low_out)
		else $error("request without peripheral enable");
	AST_NARROW: assert property (@(posedge clk_in) disable iff (!rstn_in)
		NARROW_PKG |-> !st.en_one[B_PAR_PORT] && !st.prio_one[B_PAR_PORT])
		else $error("parallel port bit present");
	AST_LOW: assert property (@(posedge clk_in) disable iff (!rstn_in)
		st.rst_ctrl[B_PRIO_EN] && st.mgie && st.pgie && |(act & ~pri)
		|=> irq_low_out)
		else $error("low request missing");
	AST_HIGH: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!st.mgie |=> !irq_high_out)
		else $error("high request without master enable");
	AST_ACK: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack held two cycles");

	// ********************
	// flag checks
	// ********************
	AST_FLAG_KEEP: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!wr_flags
		|=> (st.flags_two & $past(st.flags_two)) == $past(st.flags_two))
		else $error("flag cleared without software");
	AST_FLAG_CLEAR: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wr_flags && wdat == 8'h00 && set_two == 8'h00
		|=> st.flags_two == 8'h00)
		else $error("software clear of flags lost");
	AST_NV_WR: assert property (@(posedge clk_in) disable iff (!rstn_in)
		evt_in.nv_write_done
		|=> st.flags_two[B_NV_WR])
		else $error("write complete flag not set");
	AST_NV_QUIET: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!evt_in.nv_write_done && !st.flags_two[B_NV_WR] && !wr_flags
		|=> !st.flags_two[B_NV_WR])
		else $error("write complete flag set without a write");
	AST_BUS_COL: assert property (@(posedge clk_in) disable iff (!rstn_in)
		evt_in.bus_collision
		|=> st.flags_two[B_BUS_COL])
		else $error("bus collision flag not set");
	AST_VOLT_RISE: assert property (@(posedge clk_in) disable iff (!rstn_in)
		voltage_trip_direction_in && voltage_above_in && !st.volt_prev
		|=> st.flags_two[B_VOLT])
		else $error("rising voltage trip missed");
	AST_VOLT_FALL: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!voltage_trip_direction_in && !voltage_above_in && st.volt_prev
		|=> st.flags_two[B_VOLT])
		else $error("falling voltage trip missed");
	AST_VOLT_QUIET: assert property (@(posedge clk_in) disable iff (!rstn_in)
		voltage_above_in == st.volt_prev && !st.flags_two[B_VOLT] && !wr_flags
		|=> !st.flags_two[B_VOLT])
		else $error("voltage flag set without a trip");
	AST_TMR3: assert property (@(posedge clk_in) disable iff (!rstn_in)
		evt_in.timer_three_ovf
		|=> st.flags_two[B_TMR3])
		else $error("timer three flag not set");
	AST_CCP2_SET: assert property (@(posedge clk_in) disable iff (!rstn_in)
		evt_in.capcomp_two_evt && (capcomp_two_mode_in == MODE_CAP || capcomp_two_mode_in == MODE_CMPR)
		|=> st.flags_two[B_CCP2])
		else $error("capture compare flag not set");

	// ********************
	// register checks
	// ********************
	AST_EN_ONE_WR: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wr && hit(wb_adr_in, OFF_EN_ONE)
		|=> st.en_one == ($past(wdat) & MASK_ONE))
		else $error("first enable write lost");
	AST_EN_TWO_WR: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wr && hit(wb_adr_in, OFF_EN_TWO)
		|=> st.en_two == ($past(wdat) & MASK_TWO))
		else $error("second enable write lost");
	AST_PRIO_ONE_WR: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wr && hit(wb_adr_in, OFF_PRIO_ONE)
		|=> st.prio_one == ($past(wdat) & MASK_ONE))
		else $error("first priority write lost");
	AST_PRIO_TWO_WR: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wr && hit(wb_adr_in, OFF_PRIO_TWO)
		|=> st.prio_two == ($past(wdat) & MASK_TWO))
		else $error("second priority write lost");
	AST_PRIO_EN_WR: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wr && hit(wb_adr_in, OFF_RST_CTRL)
		|=> priority_levels_enable_out == $past(wdat[B_PRIO_EN]))
		else $error("priority enable write lost");
	AST_RI: assert property (@(posedge clk_in) disable iff (!rstn_in)
		cause_in.reset_instr
		|=> !st.rst_ctrl[B_RST_INS])
		else $error("reset instruction cause not recorded");
	AST_TO: assert property (@(posedge clk_in) disable iff (!rstn_in)
		cause_in.watchdog_timeout
		|=> !st.rst_ctrl[B_WDOG])
		else $error("watchdog cause not recorded");
	AST_PD: assert property (@(posedge clk_in) disable iff (!rstn_in)
		cause_in.sleep_entry
		|=> !st.rst_ctrl[B_SLEEP])
		else $error("power down cause not recorded");
	AST_RO: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!cause_in.watchdog_clear && !cause_in.watchdog_timeout && !cause_in.sleep_entry
		|=> st.rst_ctrl[B_WDOG] == $past(st.rst_ctrl[B_WDOG]) && st.rst_ctrl[B_SLEEP] == $past(st.rst_ctrl[B_SLEEP]))
		else $error("read-only cause bit changed");
	AST_SBOR: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!st.cfg_done
		|=> st.rst_ctrl[B_SBOR] == $past(soft_brownout_cfg_in))
		else $error("brown-out enable strap not loaded");

	// ********************
	// request and bus checks
	// ********************
	AST_HIGH_SINGLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!st.rst_ctrl[B_PRIO_EN] && st.mgie && st.pgie && |act
		|=> irq_high_out)
		else $error("single level request missing");
	AST_LOW_SINGLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!st.rst_ctrl[B_PRIO_EN]
		|=> !irq_low_out)
		else $error("low request without priority levels");
	AST_HIGH_PRIO: assert property (@(posedge clk_in) disable iff (!rstn_in)
		st.rst_ctrl[B_PRIO_EN] && st.mgie && |(act & pri)
		|=> irq_high_out)
		else $error("high request missing");
	AST_HIGH_NONE: assert property (@(posedge clk_in) disable iff (!rstn_in)
		st.rst_ctrl[B_PRIO_EN] && !(|(act & pri))
		|=> !irq_high_out)
		else $error("high request without a high source");
	AST_LOW_NONE: assert property (@(posedge clk_in) disable iff (!rstn_in)
		st.rst_ctrl[B_PRIO_EN] && !(|(act & ~pri))
		|=> !irq_low_out)
		else $error("low request without a low source");
	AST_LOW_PGIE: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!st.pgie
		|=> !irq_low_out)
		else $error("low request without peripheral enable");
	AST_NO_EN: assert property (@(posedge clk_in) disable iff (!rstn_in)
		act == 16'h0000
		|=> !irq_high_out && !irq_low_out)
		else $error("request without enabled flag");
	AST_ACK_ONE: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wb_cyc_in && wb_stb_in && !wb_ack_out
		|=> wb_ack_out)
		else $error("ack not given one cycle after request");
	AST_DAT_IDLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!wb_ack_out
		|-> wb_dat_out == 32'h00000000)
		else $error("read data outside ack");
	AST_NO_SEL: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wb_cyc_in && wb_stb_in && wb_we_in && !wb_sel_in[0] && hit(wb_adr_in, OFF_PRIO_TWO)
		|=> $stable(st.prio_two))
		else $error("write without byte lane landed");
endmodule

// ---- tb/pifp_periph_model.sv ----
// stand-in for the peripherals: one-cycle requests become event pulses and level changes
`timescale 1ns/1ps
module pifp_periph_model
	import pifp_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic [7:0] req_in,
	output pifp_evt_t       evt_out = '0,
	output logic      [1:0] cmp_out = 2'h0,
	output logic            volt_out = 1'b0
);
	// once failed the clock stays on the internal source, as the real clock logic would
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			evt_out <= '0;
			cmp_out <= 2'h0;
			volt_out <= 1'b0;
		end else begin
			evt_out.clock_fail <= req_in[B_CLK_FAIL];
			evt_out.internal_oscillator <= evt_out.internal_oscillator | req_in[B_CLK_FAIL];
			evt_out.nv_write_done <= req_in[B_NV_WR];
			evt_out.bus_collision <= req_in[B_BUS_COL];
			evt_out.timer_three_ovf <= req_in[B_TMR3];
			evt_out.capcomp_two_evt <= req_in[B_CCP2];
			cmp_out <= cmp_out ^ {1'b0, req_in[B_CMP]};
			volt_out <= volt_out ^ req_in[B_VOLT];
		end
	end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the peripheral interrupt block
`timescale 1ns/1ps
module tb
	import pifp_pkg::*;
;
	logic        clk_in, rstn_in, cyc, stb, we, sbcfg, dir;
	logic [3:0]  sel, bsel;
	logic        ack, irq_h, irq_l, ple, voltv;
	logic [4:0]  adr, a;
	logic [31:0] wdat, rd_d, rdat;
	logic [7:0]  f1, req, e1, q;
	logic [1:0]  mode, cmpv;
	pifp_evt_t   evt;
	pifp_cause_t cause;
	logic [4:0]  offs [4];
	int          error_cnt, cmp_count, cyc_cnt;

	pifp_top #(.NARROW_PKG(1'b0)) pifp_top_inst (.clk_in(clk_in), .rstn_in(rstn_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rd_d), .wb_ack_out(ack),
		.flags_one_in(f1), .evt_in(evt), .comparator_out_in(cmpv),
		.voltage_above_in(voltv), .voltage_trip_direction_in(dir),
		.capcomp_two_mode_in(mode), .cause_in(cause), .soft_brownout_cfg_in(sbcfg),
		.irq_high_out(irq_h), .irq_low_out(irq_l), .priority_levels_enable_out(ple));
	pifp_periph_model pifp_periph_model_inst (.clk_in(clk_in), .rstn_in(rstn_in),
		.req_in(req), .evt_out(evt), .cmp_out(cmpv), .volt_out(voltv));

	// ********************
	// helpers
	// ********************
	task automatic summarize();
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// holds the request until ack is sampled high, giving up with an error after 20 cycles
	task automatic bus(input logic w, input logic [4:0] ad, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		{cyc, stb, we, sel, adr, wdat} <= {2'h3, w, bsel, ad, 24'h0, d};
		do begin
			@(posedge clk_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rdat = rd_d;
		{cyc, stb} <= 2'h0;
		if (n >= 20) error_cnt++;
	endtask
	task automatic rd(input logic [4:0] ad, input logic [7:0] exp);
		bus(1'b0, ad, 8'h00);
		chk(rdat, {24'h0, exp});
	endtask
	// second-register writes lose bit 5, first-register writes keep all bits
	function automatic logic [7:0] masked(input int i, input logic [7:0] v);
		return (i % 2) ? (v & MASK_TWO) : v;
	endfunction
	task automatic fire(input logic [7:0] m);
		@(posedge clk_in);
		req <= m;
		@(posedge clk_in);
		req <= 8'h00;
	endtask
	task automatic irq(input logic [7:0] g, input logic [7:0] p, input logic h, input logic l);
		bus(1'b1, OFF_GLOBAL, g);
		bus(1'b1, OFF_PRIO_TWO, p);
		repeat (3) @(posedge clk_in);
		chk({irq_h, irq_l}, {h, l});
	endtask

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_in) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 4000) begin
			error_cnt++;
			summarize();
		end
	end

	// ********************
	// main sequence
	// ********************
	initial begin
		{rstn_in, cyc, stb, we, adr, wdat, f1, req} = '0;
		{sbcfg, dir, mode, cause} = {2'h3, MODE_CAP, 4'h0};
		{error_cnt, cmp_count, cyc_cnt} = '0;
		{sel, bsel} = 8'hFF;
		offs = '{OFF_EN_ONE, OFF_EN_TWO, OFF_PRIO_ONE, OFF_PRIO_TWO};
		void'($urandom(86060));
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		chk(ple, 1'b0);
		rd(OFF_FLAGS_TWO, RST_FLAGS);
		rd(OFF_EN_ONE, RST_EN);
		rd(OFF_EN_TWO, RST_EN);
		rd(OFF_PRIO_ONE, RST_PRIO);
		rd(OFF_PRIO_TWO, 8'hDF);
		rd(OFF_RST_CTRL, 8'h5C);
		rd(5'h1C, 8'h00);
		for (int i = 0; i < 16; i++) begin
			e1 = $urandom;
			a = offs[i % 4];
			bus(1'b1, a, e1);
			rd(a, masked(i, e1));
		end
		// a write without the low byte lane is refused
		bsel = 4'hE;
		bus(1'b1, OFF_PRIO_TWO, ~e1);
		bsel = 4'hF;
		rd(OFF_PRIO_TWO, e1 & MASK_TWO);
		// every source at once, enables left random and globals off
		fire(8'hDF);
		rd(OFF_FLAGS_TWO, 8'hDF);
		bus(1'b1, OFF_FLAGS_TWO, 8'h00);
		rd(OFF_FLAGS_TWO, 8'h00);
		mode <= MODE_PWM;
		fire(8'h01);
		rd(OFF_FLAGS_TWO, 8'h00);
		{mode, dir} <= {MODE_CMPR, 1'b0};
		fire(8'h05);
		rd(OFF_FLAGS_TWO, 8'h05);
		bus(1'b1, OFF_EN_TWO, 8'h00);
		bus(1'b1, OFF_GLOBAL, 8'hC0);
		for (int i = 0; i < 8; i++) begin
			e1 = $urandom;
			q = $urandom;
			f1 <= q;
			bus(1'b1, OFF_EN_ONE, e1);
			repeat (3) @(posedge clk_in);
			chk({irq_h, irq_l}, {|(q & e1), 1'b0});
		end
		bus(1'b1, OFF_EN_ONE, 8'hFF);
		f1 <= 8'h01;
		irq(8'h80, 8'hDF, 1'b0, 1'b0);
		irq(8'hC0, 8'h00, 1'b1, 1'b0);
		f1 <= 8'h00;
		cause.reset_instr <= 1'b1;
		@(posedge clk_in);
		cause <= '0;
		rd(OFF_RST_CTRL, 8'h4C);
		bus(1'b1, OFF_RST_CTRL, 8'hA0);
		rd(OFF_RST_CTRL, 8'h8C);
		chk(ple, 1'b1);
		bus(1'b1, OFF_EN_TWO, 8'h01);
		irq(8'hC0, 8'h00, 1'b0, 1'b1);
		irq(8'h40, 8'h00, 1'b0, 1'b0);
		irq(8'h80, 8'hDF, 1'b1, 1'b0);
		irq(8'h40, 8'hDF, 1'b0, 1'b0);
		// second reset in mid-run, brown-out strap now low
		sbcfg <= 1'b0;
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		rd(OFF_RST_CTRL, RST_CAUSE);
		rd(OFF_PRIO_TWO, RST_PRIO & MASK_TWO);
		chk({irq_h, irq_l, ple}, 3'h0);
		summarize();
	end
endmodule
